// ---- src/clock_select_cfg.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef CLOCK_SELECT_CFG_SVH
`define CLOCK_SELECT_CFG_SVH

`define MUL_CTRL_ADDR      8'hb9
`define CLK_SRC_ADDR       8'ha9
`define MUL_CTRL_RESET     8'h00
`define CLK_SRC_RESET      8'h00
`define MUL_EN_BIT         7
`define MUL_INIT_BIT       6
`define MUL_RDY_BIT        5
`define MUL_SEL_LSB        0
`define USB_SRC_LSB        4
`define SYS_SRC_LSB        0
`define MUL_FACTOR         4
`define CLK_PERIOD_NS      8
`define MUL_LOCK_NS        1000
`define MUL_LOCK_CYCLES    ((`MUL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_GAP_NS      64
`define SWITCH_GAP_CYCLES  ((`SWITCH_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MUL_IN_INTERNAL    2'h0
`define MUL_IN_EXTERNAL    2'h1
`define MUL_IN_EXT_HALF    2'h2
`define SYS_INTERNAL       2'h0
`define SYS_EXTERNAL       2'h1
`define SYS_MUL_HALF       2'h2
`define SYS_RESERVED       2'h3

`endif

// ---- src/clock_select_pkg.sv ----
// Types shared by the clock control block
package clock_select_pkg;
  typedef enum logic [1:0] {
    SW_RUN,
    SW_GATE_OFF,
    SW_GATE_ON
  } switch_state_e;
  typedef logic [7:0] sfr_byte_t;
endpackage : clock_select_pkg

// ---- src/level_sync3.sv ----
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/10ps
module level_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted only once the second and third stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (ce && (s2_q == s3_q)) begin
      level_q <= s3_q;
    end
  end
endmodule : level_sync3

// ---- src/clock_select.sv ----
// Clock multiplier control, system and USB clock source selection
`timescale 1ns/10ps
`include "clock_select_cfg.svh"
module clock_select
  import clock_select_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       ext_osc_settled,
  output logic            crystal_valid_flag,
  output logic            multiplier_enable,
  output logic            multiplier_initialise,
  output logic      [1:0] multiplier_input_select,
  output logic            multiplier_ready_flag,
  output logic      [1:0] system_clock_source,
  output logic            system_clock_gate,
  output logic      [2:0] usb_clock_source,
  output logic            ext_osc_to_peripherals
);
  localparam int unsigned LOCK_CYCLES = `MUL_LOCK_CYCLES;
  localparam int unsigned GAP_CYCLES  = `SWITCH_GAP_CYCLES;

  logic          addr_mul;
  logic          addr_sel;
  logic          mul_drop;
  logic          wr_mul;
  logic          wr_sel;
  logic          init_rise;
  logic          ext_valid;
  logic [1:0]    sys_req_q;
  logic [7:0]    lock_cnt_q;
  logic [3:0]    gap_cnt_q;
  switch_state_e sw_state_q;
  sfr_byte_t     rd_d;

  assign addr_mul  = (sfr_addr == `MUL_CTRL_ADDR);
  assign addr_sel  = (sfr_addr == `CLK_SRC_ADDR);
  assign wr_mul    = ce && sfr_wr && addr_mul;
  assign wr_sel    = ce && sfr_wr && addr_sel;
  assign init_rise = wr_mul && sfr_wdata[`MUL_INIT_BIT] && sfr_wdata[`MUL_EN_BIT]
                     && !multiplier_initialise;
  // Clearing enable or initialise drops ready at the write edge, not a cycle late
  assign mul_drop  = wr_mul && !(sfr_wdata[`MUL_INIT_BIT] && sfr_wdata[`MUL_EN_BIT]);

  // Settle pin is asynchronous, so it passes the three-stage filter
  level_sync3 u_xtal_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in (ext_osc_settled),
    .level_q  (ext_valid)
  );

  // Flag follows the filtered settle level of the oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_valid_flag <= 1'b0;
    end else if (ce) begin
      crystal_valid_flag <= ext_valid;
    end
  end

  // External oscillator path to timers and USB never depends on the system source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_osc_to_peripherals <= 1'b0;
    end else if (ce) begin
      ext_osc_to_peripherals <= crystal_valid_flag;
    end
  end

  // Multiplier control; bits 4..2 have no storage, so writes there vanish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplier_enable <= 1'(`MUL_CTRL_RESET >> `MUL_EN_BIT);
    end else if (wr_mul) begin
      multiplier_enable <= sfr_wdata[`MUL_EN_BIT];
    end
  end

  // Initialise without enable is stored as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplier_initialise <= 1'(`MUL_CTRL_RESET >> `MUL_INIT_BIT);
    end else if (wr_mul) begin
      multiplier_initialise <= sfr_wdata[`MUL_INIT_BIT] && sfr_wdata[`MUL_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplier_input_select <= 2'(`MUL_CTRL_RESET >> `MUL_SEL_LSB);
    end else if (wr_mul) begin
      multiplier_input_select <= sfr_wdata[`MUL_SEL_LSB +: 2];
    end
  end

  // Lock timer restarts on each fresh initialise; disabling drops ready at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q            <= 8'h00;
      multiplier_ready_flag <= 1'b0;
    end else if (ce) begin
      if (init_rise || mul_drop || !multiplier_enable || !multiplier_initialise) begin
        lock_cnt_q            <= 8'h00;
        multiplier_ready_flag <= 1'b0;
      end else if (lock_cnt_q == 8'(LOCK_CYCLES - 1)) begin
        multiplier_ready_flag <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 8'h01;
      end
    end
  end

  // USB source is a plain select; reserved codes are stored as written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_clock_source <= 3'(`CLK_SRC_RESET >> `USB_SRC_LSB);
    end else if (wr_sel) begin
      usb_clock_source <= sfr_wdata[`USB_SRC_LSB +: 3];
    end
  end

  // Reserved system code leaves the previous request standing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_req_q <= 2'(`CLK_SRC_RESET >> `SYS_SRC_LSB);
    end else if (wr_sel && (sfr_wdata[`SYS_SRC_LSB +: 2] != `SYS_RESERVED)) begin
      sys_req_q <= sfr_wdata[`SYS_SRC_LSB +: 2];
    end
  end

  // Break before make: gate off, change source, gate on, so no runt pulse escapes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_state_q          <= SW_RUN;
      gap_cnt_q           <= 4'h0;
      system_clock_source <= `SYS_INTERNAL;
      system_clock_gate   <= 1'b1;
    end else if (ce) begin
      case (sw_state_q)
        SW_RUN: begin
          if (sys_req_q != system_clock_source) begin
            system_clock_gate <= 1'b0;
            gap_cnt_q         <= 4'h0;
            sw_state_q        <= SW_GATE_OFF;
          end
        end
        SW_GATE_OFF: begin
          if (gap_cnt_q == 4'(GAP_CYCLES - 1)) begin
            system_clock_source <= sys_req_q;
            gap_cnt_q           <= 4'h0;
            sw_state_q          <= SW_GATE_ON;
          end else begin
            gap_cnt_q <= gap_cnt_q + 4'h1;
          end
        end
        SW_GATE_ON: begin
          if (gap_cnt_q == 4'(GAP_CYCLES - 1)) begin
            system_clock_gate <= 1'b1;
            sw_state_q        <= SW_RUN;
          end else begin
            gap_cnt_q <= gap_cnt_q + 4'h1;
          end
        end
        default: begin
          sw_state_q        <= SW_RUN;
          system_clock_gate <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unused bits return zero
  always_comb begin
    rd_d = 8'h00;
    if (addr_mul) begin
      rd_d[`MUL_EN_BIT]       = multiplier_enable;
      rd_d[`MUL_INIT_BIT]     = multiplier_initialise;
      rd_d[`MUL_RDY_BIT]      = multiplier_ready_flag;
      rd_d[`MUL_SEL_LSB +: 2] = multiplier_input_select;
    end else if (addr_sel) begin
      rd_d[`USB_SRC_LSB +: 3] = usb_clock_source;
      rd_d[`SYS_SRC_LSB +: 2] = sys_req_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      sfr_rdata <= rd_d;
    end
  end
endmodule : clock_select

// ---- dv/osc_source.sv ----
// Behavioural external oscillator that settles some cycles after enable
`timescale 1ns/10ps
module osc_source #(
  parameter int SETTLE = 50
) (
  input  wire logic clk,
  input  wire logic enable,
  output logic      settled
);
  int n = 0;
  initial settled = 1'b0;
  // Drops at once on disable, so a stopped crystal is never reported as good
  always @(posedge clk) begin
    n <= enable ? n + 1 : 0;
    settled <= enable && n >= SETTLE;
  end
endmodule : osc_source

// ---- dv/clock_select_asserts.sv ----
// Port-level checks for the clock control block
`timescale 1ns/10ps
module clock_select_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       ext_osc_settled,
  input wire logic       crystal_valid_flag,
  input wire logic       multiplier_initialise,
  input wire logic       multiplier_ready_flag,
  input wire logic [1:0] multiplier_input_select,
  input wire logic [1:0] system_clock_source,
  input wire logic       system_clock_gate,
  input wire logic [2:0] usb_clock_source
);
  logic [7:0] wd_q;
  wire        wb = ce && sfr_wr && sfr_addr == 8'hb9;
  wire        wa = ce && sfr_wr && sfr_addr == 8'ha9;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Write data kept one cycle so results are compared after the edge
  always_ff @(posedge clk) wd_q <= sfr_wdata;
  a_ctrl_write: assert property (wb |=> multiplier_initialise == &wd_q[7:6]
    && multiplier_input_select == wd_q[1:0]) else $error("control write lost");
  a_ready_lock: assert property (wb && sfr_wdata[7:6] == 2'h3 && !multiplier_initialise
    |-> ##125 !multiplier_ready_flag ##1 multiplier_ready_flag) else $error("lock time off");
  a_ready_drop: assert property (wb && sfr_wdata[7:6] != 2'h3 |=> !multiplier_ready_flag)
    else $error("ready kept");
  a_read_unused: assert property (ce && sfr_rd && sfr_addr == 8'hb9
    |=> sfr_rdata[4:2] == 3'h0) else $error("unused bits set");
  a_usb_write: assert property (wa |=> usb_clock_source == wd_q[6:4])
    else $error("usb source lost");
  a_gate_gap: assert property ($fell(system_clock_gate) |-> ##16 $rose(system_clock_gate))
    else $error("gate gap off");
  a_src_gated: assert property ($changed(system_clock_source)
    |-> !system_clock_gate ##8 system_clock_gate) else $error("ungated switch");
  a_xtal_valid: assert property ($rose(ext_osc_settled)
    |-> ##[4:6] $rose(crystal_valid_flag)) else $error("valid flag late");
endmodule : clock_select_asserts
bind clock_select clock_select_asserts i_chk (.*);

// ---- dv/clock_select_bench.sv ----
// Self-checking bench for the clock control block
`timescale 1ns/10ps
module clock_select_bench;
  logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic       osc_on = 1'b0, ext_osc_settled, crystal_valid_flag, multiplier_enable;
  logic       multiplier_initialise, multiplier_ready_flag, system_clock_gate;
  logic       ext_osc_to_peripherals;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [1:0] multiplier_input_select, system_clock_source;
  logic [2:0] usb_clock_source;
  logic [1:0] req [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0] app [4] = '{2'h1, 2'h1, 2'h2, 2'h0};
  int         errors = 0, checks_done = 0, cycles = 0;
  always #4 clk = ~clk;
  clock_select i_dut (.*);
  osc_source i_osc (.clk, .enable(osc_on), .settled(ext_osc_settled));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #1;
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #1;
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask : rd
  task automatic final_report();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Ceiling is about three times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    osc_on = 1'b1;
    rd(8'hb9, 8'h00);
    rd(8'h5a, 8'h00);
    wr(8'hb9, 8'h7e);
    rd(8'hb9, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(8'ha9, 8'(i * 16));
      chk(8'(usb_clock_source), 8'(i));
    end
    rd(8'ha9, 8'h70);
    wr(8'hb9, 8'h00);
    wr(8'hb9, 8'h80);
    // Over 5 us before the lock starts; the oscillator settles meanwhile
    // The model starts fast, so this wait stands in for the crystal start-up delay
    repeat (650) @(posedge clk);
    #1 chk(8'(crystal_valid_flag), 8'h01);
    chk(8'(ext_osc_to_peripherals), 8'h01);
    wr(8'hb9, 8'hc0);
    rd(8'hb9, 8'hc0);
    repeat (130) @(posedge clk);
    rd(8'hb9, 8'he0);
    for (int i = 0; i < 4; i++) begin
      wr(8'ha9, {6'h00, req[i]});
      repeat (25) @(posedge clk);
      #1 chk(8'(system_clock_source), 8'(app[i]));
    end
    ce = 1'b0;
    wr(8'hb9, 8'h00);
    ce = 1'b1;
    chk(8'(multiplier_ready_flag), 8'h01);
    wr(8'hb9, 8'h81);
    chk(8'(multiplier_ready_flag), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'hb9, 8'(i));
      chk(8'(multiplier_input_select), 8'(i));
    end
    // Full and low speed USB source settings; the system request stays internal
    wr(8'ha9, 8'h00);
    chk(8'(usb_clock_source), 8'h00);
    wr(8'ha9, 8'h10);
    chk(8'(usb_clock_source), 8'h01);
    wr(8'ha9, 8'h50);
    rd(8'ha9, 8'h50);
    wr(8'hb9, 8'h01);
    rd(8'hb9, 8'h01);
    final_report();
  end
endmodule : clock_select_bench
